// [lpmc_consts.vh]
// constants for the low-power mode controller
// assumes a 100 MHz core clock and an 8-bit register port
`ifndef LPMC_CONSTS_VH
`define LPMC_CONSTS_VH
`define LPMC_A_CTRL        4'h0
`define LPMC_A_STATUS      4'h1
`define LPMC_A_MASK        4'h2
`define LPMC_A_WAKE_LO     4'h3
`define LPMC_A_WAKE_HI     4'h4
`define LPMC_A_WAKE_MID    4'h5
`define LPMC_A_STATE       4'h6
`define LPMC_A_SRC_LO      4'h7
`define LPMC_A_SRC_HI      4'h8
`define LPMC_CTRL_STOP     0
`define LPMC_CTRL_STBY     1
`define LPMC_CTRL_LPREG    2
`define LPMC_CTRL_BKRAM    3
`define LPMC_ST_STOPWK     0
`define LPMC_ST_STBYWK     1
`define LPMC_ST_BATT       2
`define LPMC_ST_BKEN       3
`define LPMC_WAKE_NS       100
`define LPMC_CLK_NS        10
`define LPMC_WAKE_CYC      4'ha
`endif

// [lpmc_sync.v]
// two-flop synchroniser for a level from the always-on side
// assumes the input is already a stable level held by a latch
`timescale 1ns/1ps
module lpmc_sync (
  // clock and reset
  input  wire clk,
  input  wire rst_n,
  // level in and out
  input  wire din,
  output reg  dout
);
  reg meta_q;
  always @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      dout   <= 1'b0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule

// [lpmc_wake_latch.v]
// always-on wake latch: sets from a source, cleared on exit acknowledge
// assumes the always-on clock keeps running in low-power states
`timescale 1ns/1ps
module lpmc_wake_latch #(
  parameter W = 24
) (
  // always-on clock and reset
  input  wire         clk,
  input  wire         rst_n,
  // sources and control
  input  wire [W-1:0] src,
  input  wire [W-1:0] enable,
  input  wire         clear,
  output reg  [W-1:0] held
);
  always @(posedge clk) begin
    if (!rst_n)
      held <= {W{1'b0}};
    else
      held <= (held & {W{~clear}}) | (src & enable);
  end
endmodule

// [lpmc_top.v]
// low-power mode controller: stop and standby entry, wake collection
// assumes wake sources are synchronous pulses or levels from the always-on side
`timescale 1ns/1ps
`include "lpmc_consts.vh"
// Summary of operation
// [R01] stop mode exits on any of 16 lines, supply, rtc, usb, ethernet events
// [R02] stop disables external crystal; regulator normal or low-power by software
// [R03] standby switches off the regulator, powering down the 1.2 V domain
// [R04] standby also stops main pll, internal rc and external crystal oscillators
// [R05] after standby only backup registers and selected backup sram are kept
// [R06] standby exits on reset pin, watchdog reset, wake pin rise or rtc event
// [R07] rtc, watchdog and their clock sources keep running in stop and standby
// [R08] on battery supply, interrupts and rtc events do not leave battery operation
// [R09] board straps regulator-disable: ground gives regulator on, supply gives off
// [R10] wake sources are latched in always-on logic then synchronised before exit; reset pin and watchdog reset bypass both
module lpmc_top (
  // clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // register port
  input  wire [3:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  // wake sources
  input  wire [15:0] external_event_lines,
  input  wire       supply_threshold_detector,
  input  wire [3:0] rtc_event,
  input  wire       usb_wake,
  input  wire       eth_wake,
  input  wire       external_reset_pin_n,
  input  wire       independent_watchdog_rst,
  input  wire       wake_pin,
  // supply and strap
  input  wire       main_supply_ok,
  input  wire       regulator_disable_strap,
  // power and clock control
  output reg        regulator_on,
  output reg        regulator_lp,
  output reg        core_domain_on,
  output reg        pll_en,
  output reg        internal_rc_oscillator_en,
  output reg        external_crystal_oscillator_en,
  output reg        rtc_wdg_clk_en,
  output reg        backup_sram_keep,
  output reg        core_reset_n,
  output reg        battery_mode,
  output reg        irq
);
  localparam S_RUN   = 3'h0;
  localparam S_STOP  = 3'h1;
  localparam S_STBY  = 3'h2;
  localparam S_WAKE  = 3'h3;
  localparam S_BATT  = 3'h4;

  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg  [3:0]  ctrl_q;
  reg  [3:0]  status_q;
  reg  [3:0]  mask_q;
  reg  [23:0] wake_en_q;
  reg  [3:0]  wcnt_q;
  reg         wake_pin_q;
  reg         strap_q;
  reg         strap_taken_q;
  reg         ack_q;
  reg         from_stby_q;
  wire [23:0] src_all;
  wire [23:0] held;
  wire        stop_held;
  wire        stby_held;
  wire        stop_sync;
  wire        stby_sync;
  wire        wake_entry;
  wire        stby_exit;
  wire        stop_src;
  wire        stby_src;
  wire [3:0]  ev_set;

  function [7:0] lpmc_byte;
    input [23:0] v;
    input [1:0]  sel;
    begin
      if (sel == 2'h0)
        lpmc_byte = v[7:0];
      else if (sel == 2'h1)
        lpmc_byte = v[15:8];
      else
        lpmc_byte = v[23:16];
    end
  endfunction

  // core domain powered in run, stop and the wake sequence
  function lpmc_powered;
    input [2:0] s;
    begin
      lpmc_powered = (s == S_RUN) || (s == S_STOP) || (s == S_WAKE);
    end
  endfunction

  // register write decode for one address
  function lpmc_hit;
    input       strobe;
    input [3:0] addr;
    input [3:0] target;
    begin
      lpmc_hit = strobe && (addr == target);
    end
  endfunction

  // wake sources in one vector; bits 16..23 are the other event sources
  assign src_all = {eth_wake, usb_wake, rtc_event, supply_threshold_detector,
                    wake_pin & ~wake_pin_q, external_event_lines};

  lpmc_wake_latch #(
    .W (24)
  ) u_latch (
    .clk    (clk),
    .rst_n  (rst_n),
    .src    (src_all),
    .enable (wake_en_q),
    .clear  (ack_q),
    .held   (held)
  ); // R10

  // stop wakes from every latched source but the wake pin; standby wakes only from latched wake pin and rtc
  assign stop_held = (|held[15:0]) | (|held[23:17]); // R01
  assign stby_held = held[16] | (|held[21:18]); // R06

  lpmc_sync u_sync_stop (
    .clk   (clk),
    .rst_n (rst_n),
    .din   (stop_held),
    .dout  (stop_sync)
  ); // R10

  lpmc_sync u_sync_stby (
    .clk   (clk),
    .rst_n (rst_n),
    .din   (stby_held),
    .dout  (stby_sync)
  ); // R10

  assign stop_src = stop_sync; // R01
  assign stby_src = ~external_reset_pin_n | independent_watchdog_rst | stby_sync; // R06

  always @* begin
    state_d = state_q;
    case (state_q)
      S_RUN: begin
        if (!main_supply_ok)
          state_d = S_BATT;
        else if (ctrl_q[`LPMC_CTRL_STBY])
          state_d = S_STBY;
        else if (ctrl_q[`LPMC_CTRL_STOP])
          state_d = S_STOP;
      end
      S_STOP: begin
        if (!main_supply_ok)
          state_d = S_BATT;
        else if (stop_src)
          state_d = S_WAKE; // R01
      end
      S_STBY: begin
        if (!main_supply_ok)
          state_d = S_BATT;
        else if (stby_src)
          state_d = S_WAKE; // R06
      end
      S_WAKE: begin
        if (wcnt_q == 4'h0)
          state_d = S_RUN;
      end
      S_BATT: begin
        if (main_supply_ok)
          state_d = S_STBY; // R08
      end
      default: state_d = S_RUN;
    endcase
  end

  assign wake_entry = (state_d == S_WAKE) && (state_q != S_WAKE);
  assign stby_exit  = (state_q == S_STBY) && (state_d == S_WAKE);
  assign ev_set     = {1'b0, (state_q != S_BATT) & (state_d == S_BATT),
                       stby_exit, (state_q == S_STOP) & (state_d == S_WAKE)};

  // mode state, wake counter and latch acknowledge
  always @(posedge clk) begin
    if (!rst_n) begin
      state_q     <= S_RUN;
      wcnt_q      <= 4'h0;
      wake_pin_q  <= 1'b0;
      ack_q       <= 1'b0;
      from_stby_q <= 1'b0;
    end else begin
      state_q    <= state_d;
      wake_pin_q <= wake_pin;
      ack_q      <= (state_q == S_WAKE) || (state_q == S_BATT); // R08
      if (wake_entry)
        wcnt_q <= `LPMC_WAKE_CYC;
      else if (wcnt_q != 4'h0)
        wcnt_q <= wcnt_q - 4'h1;
      if (stby_exit)
        from_stby_q <= 1'b1; // R05
      else if (state_d != S_WAKE)
        from_stby_q <= 1'b0;
    end
  end

  // strap sampled once after reset release
  always @(posedge clk) begin
    if (!rst_n) begin
      strap_q       <= 1'b0;
      strap_taken_q <= 1'b0;
    end else if (!strap_taken_q) begin
      strap_q       <= regulator_disable_strap; // R09
      strap_taken_q <= 1'b1;
    end
  end

  // control register; leaving stop or standby through the wake sequence clears the mode request
  always @(posedge clk) begin
    if (!rst_n) begin
      ctrl_q <= 4'h0;
    end else begin
      if (state_q == S_WAKE)
        ctrl_q[1:0] <= 2'b00;
      else if (lpmc_hit(reg_wr, reg_addr, `LPMC_A_CTRL))
        ctrl_q <= reg_wdata[3:0];
      // standby loses everything except the backup sram choice
      if (stby_exit)
        ctrl_q[`LPMC_CTRL_LPREG] <= 1'b0; // R05
    end
  end

  // interrupt mask and wake enables
  always @(posedge clk) begin
    if (!rst_n) begin
      mask_q    <= 4'h0;
      wake_en_q <= 24'hffffff;
    end else begin
      if (lpmc_hit(reg_wr, reg_addr, `LPMC_A_MASK))
        mask_q <= reg_wdata[3:0];
      if (lpmc_hit(reg_wr, reg_addr, `LPMC_A_WAKE_LO))
        wake_en_q[7:0] <= reg_wdata;
      else if (lpmc_hit(reg_wr, reg_addr, `LPMC_A_WAKE_MID))
        wake_en_q[15:8] <= reg_wdata;
      else if (lpmc_hit(reg_wr, reg_addr, `LPMC_A_WAKE_HI))
        wake_en_q[23:16] <= reg_wdata;
    end
  end

  // sticky status, set wins over write-one clear
  always @(posedge clk) begin
    if (!rst_n) begin
      status_q <= 4'h0;
      irq      <= 1'b0;
    end else begin
      if (lpmc_hit(reg_wr, reg_addr, `LPMC_A_STATUS))
        status_q <= (status_q & ~reg_wdata[3:0]) | ev_set;
      else
        status_q <= status_q | ev_set;
      irq <= |(status_q & mask_q);
    end
  end

  // read data stands one cycle after the read strobe
  always @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      if (!reg_rd)
        reg_rdata <= 8'h00;
      else if (reg_addr == `LPMC_A_CTRL)
        reg_rdata <= {4'h0, ctrl_q};
      else if (reg_addr == `LPMC_A_STATUS)
        reg_rdata <= {4'h0, status_q};
      else if (reg_addr == `LPMC_A_MASK)
        reg_rdata <= {4'h0, mask_q};
      else if (reg_addr == `LPMC_A_WAKE_LO)
        reg_rdata <= lpmc_byte(wake_en_q, 2'h0);
      else if (reg_addr == `LPMC_A_WAKE_MID)
        reg_rdata <= lpmc_byte(wake_en_q, 2'h1);
      else if (reg_addr == `LPMC_A_WAKE_HI)
        reg_rdata <= lpmc_byte(wake_en_q, 2'h2);
      else if (reg_addr == `LPMC_A_STATE)
        reg_rdata <= {3'h0, strap_q, 1'b0, state_q};
      else if (reg_addr == `LPMC_A_SRC_LO)
        reg_rdata <= lpmc_byte(held, 2'h0);
      else if (reg_addr == `LPMC_A_SRC_HI)
        reg_rdata <= lpmc_byte(held, 2'h2);
      else
        reg_rdata <= 8'h00;
    end
  end

  // power outputs registered from the next state; backup sram keep from the control register
  always @(posedge clk) begin
    if (!rst_n) begin
      regulator_on                   <= 1'b1;
      regulator_lp                   <= 1'b0;
      core_domain_on                 <= 1'b1;
      pll_en                         <= 1'b1;
      internal_rc_oscillator_en      <= 1'b1;
      external_crystal_oscillator_en <= 1'b1;
      rtc_wdg_clk_en                 <= 1'b1;
      backup_sram_keep               <= 1'b0;
      core_reset_n                   <= 1'b0;
      battery_mode                   <= 1'b0;
    end else begin
      rtc_wdg_clk_en   <= 1'b1; // R07
      backup_sram_keep <= ctrl_q[`LPMC_CTRL_BKRAM]; // R05
      battery_mode     <= (state_d == S_BATT); // R08
      regulator_on     <= !strap_q && lpmc_powered(state_d); // R03
      regulator_lp     <= (state_d == S_STOP) & ctrl_q[`LPMC_CTRL_LPREG]; // R02
      core_domain_on   <= lpmc_powered(state_d); // R03
      pll_en           <= (state_d == S_RUN); // R04
      internal_rc_oscillator_en      <= (state_d != S_STBY && state_d != S_BATT); // R04
      external_crystal_oscillator_en <= (state_d == S_RUN); // R02
      core_reset_n     <= (state_d == S_RUN) | (state_d == S_STOP) |
                          ((state_d == S_WAKE) & ~stby_exit & ~from_stby_q); // R05
    end
  end
endmodule

// [lpmc_assertions.sv]
// checker for the low-power mode controller
// sees only the top module ports; bound after the module
`timescale 1ns/1ps
module lpmc_checker (
  input wire        clk,
  input wire        rst_n,
  input wire [3:0]  reg_addr,
  input wire [7:0]  reg_wdata,
  input wire        reg_wr,
  input wire [15:0] external_event_lines,
  input wire        main_supply_ok,
  input wire        regulator_disable_strap,
  input wire        regulator_on,
  input wire        regulator_lp,
  input wire        core_domain_on,
  input wire        pll_en,
  input wire        internal_rc_oscillator_en,
  input wire        external_crystal_oscillator_en,
  input wire        rtc_wdg_clk_en,
  input wire        core_reset_n,
  input wire        battery_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // standby request from run, then power down two edges later
  sequence s_stby_wr;
    reg_wr && reg_addr == 4'h0 && reg_wdata[1] && pll_en && core_reset_n;
  endsequence
  sequence s_pwr_off;
    ##2 !core_domain_on && !regulator_on;
  endsequence
  a_stop_entry: assert property (reg_wr && reg_addr == 4'h0 && reg_wdata[1:0] == 2'b01
    && pll_en && core_reset_n |-> ##2 !external_crystal_oscillator_en && !pll_en)
    else $error("stop entry left oscillators on");
  a_stby_entry: assert property (s_stby_wr |-> s_pwr_off)
    else $error("standby entry left power on");
  a_stby_clocks: assert property (!core_domain_on |-> !pll_en
    && !internal_rc_oscillator_en && !external_crystal_oscillator_en)
    else $error("clock running with domain off");
  a_stby_core_rst: assert property (!core_domain_on |-> !core_reset_n)
    else $error("core out of reset with domain off");
  a_aon_clocks: assert property (rtc_wdg_clk_en)
    else $error("always-on clocks stopped");
  a_batt_hold: assert property (battery_mode && !main_supply_ok |=> battery_mode)
    else $error("battery state left on an event");
  a_wake_sync: assert property ($rose(|external_event_lines)
    && regulator_lp |-> regulator_lp [*3])
    else $error("wake faster than latch and sync");
  a_strap_off: assert property (core_reset_n && $past(core_reset_n)
    && regulator_disable_strap |-> !regulator_on)
    else $error("regulator on with strap high");
endmodule
bind lpmc_top lpmc_checker i_lpmc_checker (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .external_event_lines(external_event_lines),
  .main_supply_ok(main_supply_ok), .regulator_disable_strap(regulator_disable_strap),
  .regulator_on(regulator_on), .regulator_lp(regulator_lp),
  .core_domain_on(core_domain_on), .pll_en(pll_en),
  .internal_rc_oscillator_en(internal_rc_oscillator_en), .rtc_wdg_clk_en(rtc_wdg_clk_en),
  .external_crystal_oscillator_en(external_crystal_oscillator_en),
  .core_reset_n(core_reset_n), .battery_mode(battery_mode));

// [lpmc_src_model.sv]
// wake source model: pulses one chosen source for two cycles
// assumes the bench raises fire for one cycle
`timescale 1ns/1ps
module lpmc_src_model (
  // clock and request
  input  wire        clk,
  input  wire        fire,
  input  wire [4:0]  idx,
  // wake sources
  output wire [15:0] external_event_lines,
  output wire        supply_threshold_detector,
  output wire [3:0]  rtc_event,
  output wire        usb_wake,
  output wire        eth_wake,
  output wire        external_reset_pin_n,
  output wire        independent_watchdog_rst,
  output wire        wake_pin
);
  reg  [1:0]  cnt_q = 2'h0;
  reg  [4:0]  cur_q = 5'h00;
  wire [31:0] hot   = (cnt_q != 2'h0) ? (32'h1 << cur_q) : 32'h0;
  always @(posedge clk) begin
    if (fire) begin
      cnt_q <= 2'h2;
      cur_q <= idx;
    end else if (cnt_q != 2'h0) begin
      cnt_q <= cnt_q - 2'h1;
    end
  end
  assign external_event_lines      = hot[15:0];
  assign wake_pin                  = hot[16];
  assign supply_threshold_detector = hot[17];
  assign rtc_event                 = hot[21:18];
  assign usb_wake                  = hot[22];
  assign eth_wake                  = hot[23];
  assign external_reset_pin_n      = ~hot[24];
  assign independent_watchdog_rst  = hot[25];
endmodule

// [tb_top.sv]
// bench for the low-power mode controller
// drives the register port and the source model
`timescale 1ns/1ps
module tb_top;
  reg clk = 1'b0, rst_n = 1'b0, wr_q = 1'b0, rd_q = 1'b0, sup = 1'b1, strap = 1'b0, fire = 1'b0;
  reg  [3:0]  adr = 4'h0;
  reg  [7:0]  wd = 8'h00;
  reg  [4:0]  idx = 5'h00;
  wire [7:0]  rdat;
  wire [15:0] ext;
  wire [3:0]  rtc;
  wire sd, usb, eth, pin_n, wdg, wk, ron, rlp, dom, pll, rc, xt, aon, keep, crn, bat, irq;
  int error_cnt = 0;
  int samples_checked = 0;
  lpmc_src_model i_lpmc_src_model (.clk(clk), .fire(fire), .idx(idx),
    .external_event_lines(ext), .supply_threshold_detector(sd), .rtc_event(rtc),
    .usb_wake(usb), .eth_wake(eth), .external_reset_pin_n(pin_n),
    .independent_watchdog_rst(wdg), .wake_pin(wk));
  lpmc_top i_lpmc_top (.clk(clk), .rst_n(rst_n), .reg_addr(adr), .reg_wdata(wd),
    .reg_wr(wr_q), .reg_rd(rd_q), .reg_rdata(rdat), .external_event_lines(ext),
    .supply_threshold_detector(sd), .rtc_event(rtc), .usb_wake(usb), .eth_wake(eth),
    .external_reset_pin_n(pin_n), .independent_watchdog_rst(wdg), .wake_pin(wk),
    .main_supply_ok(sup), .regulator_disable_strap(strap), .regulator_on(ron),
    .regulator_lp(rlp), .core_domain_on(dom), .pll_en(pll), .internal_rc_oscillator_en(rc),
    .external_crystal_oscillator_en(xt), .rtc_wdg_clk_en(aon), .backup_sram_keep(keep),
    .core_reset_n(crn), .battery_mode(bat), .irq(irq));
  initial forever #5 clk = ~clk;
  task results;
    if (error_cnt == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input [7:0] e, input [7:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task wr(input [3:0] a, input [7:0] d);
    @(posedge clk);
    wr_q <= 1'b1; adr <= a; wd <= d;
    @(posedge clk);
    wr_q <= 1'b0;
  endtask
  task rd(input [3:0] a, output [7:0] d);
    @(posedge clk);
    rd_q <= 1'b1; adr <= a;
    @(posedge clk);
    rd_q <= 1'b0;
    #1 d = rdat;
  endtask
  task kick(input [4:0] i);
    @(posedge clk);
    fire <= 1'b1; idx <= i;
    @(posedge clk);
    fire <= 1'b0;
  endtask
  // waits for the core reset (r=1) or the crystal (r=0) to come back
  task wt(input bit r);
    int k;
    k = 0;
    while (((r ? crn : xt) !== 1'b1) && k < 80) begin
      @(posedge clk);
      k++;
    end
    if (k == 80) begin
      chk("wait", 8'h01, 8'h00);
      results();
    end
    #1;
  endtask
  task t_reset;
    reg [7:0] d;
    rd(4'h3, d); chk("wake_lo", 8'hff, d);
    rd(4'h5, d); chk("wake_mid", 8'hff, d);
    rd(4'h4, d); chk("wake_hi", 8'hff, d);
    wr(4'hf, 8'h5a);
    rd(4'hf, d); chk("unmapped", 8'h00, d);
    chk("run_out", 8'hbf, {ron, rlp, dom, pll, rc, xt, aon, crn});
  endtask
  task t_stop;
    reg [7:0] d;
    wr(4'h2, 8'h01);
    for (int i = 0; i < 24; i++) if (i != 16) begin
      wr(4'h0, {5'h0, i[0], 2'b01});
      cyc(2);
      chk("stop_out", {4'h0, i[0], 3'h7}, {2'h0, xt, pll, rlp, ron, dom, aon});
      kick(i[4:0]);
      wt(0);
      rd(4'h1, d); chk("stop_wake", 8'h01, {6'h0, d[1:0]});
      chk("irq_set", 8'h01, {7'h0, irq});
      wr(4'h1, 8'h01);
      rd(4'h1, d); chk("irq_clr", 8'h00, {7'h0, irq});
    end
    wr(4'h3, 8'hfe);
    wr(4'h0, 8'h01);
    kick(5'h00);
    cyc(30); chk("masked", 8'h00, {7'h0, xt});
    kick(5'h01);
    wt(0);
    wr(4'h3, 8'hff);
    wr(4'h1, 8'h01);
  endtask
  task t_stby;
    reg [7:0] d;
    int src[7] = '{16, 18, 19, 20, 21, 24, 25};
    for (int i = 0; i < 7; i++) begin
      wr(4'h0, 8'h0a);
      cyc(2);
      chk("stby_out", 8'h05, {dom, ron, pll, rc, xt, keep, crn, aon});
      kick(5'h00);
      cyc(30); chk("stby_hold", 8'h00, {7'h0, crn});
      rd(4'h7, d); chk("src_lo", 8'h01, d);
      kick(src[i][4:0]);
      wt(1);
      rd(4'h1, d); chk("stby_wake", 8'h02, {6'h0, d[1:0]});
      wr(4'h1, 8'h02);
    end
  endtask
  task t_batt;
    reg [7:0] d;
    @(posedge clk) sup <= 1'b0;
    cyc(5); chk("batt_in", 8'h01, {7'h0, bat});
    kick(5'h00);
    kick(5'h12);
    cyc(30); chk("batt_hold", 8'h01, {7'h0, bat});
    @(posedge clk) sup <= 1'b1;
    cyc(5); chk("batt_stby", 8'h00, {7'h0, crn});
    kick(5'h10);
    wt(1);
    rd(4'h1, d); chk("batt_flag", 8'h04, {5'h0, d[2], 2'h0});
    wr(4'h1, 8'h07);
  endtask
  task t_strap(input bit s);
    reg [7:0] d;
    @(posedge clk) rst_n <= 1'b0;
    strap <= s;
    cyc(5);
    @(posedge clk) rst_n <= 1'b1;
    cyc(3); chk("strap", {7'h0, ~s}, {7'h0, ron});
    rd(4'h6, d); chk("state_reg", {3'h0, s, 4'h0}, d);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    cyc(3);
    t_reset();
    t_stop();
    t_stby();
    t_batt();
    t_strap(1'b1);
    t_strap(1'b0);
    results();
  end
endmodule
